// >>> common/cfg_words_pkg.sv
package cfg_words_pkg;

  // address map of the configuration space
  localparam logic [23:0] CFG_SPACE_LO = 24'h800000;
  localparam logic [23:0] CFG_SPACE_HI = 24'hFFFFFF;
  localparam logic [23:0] CFG_BASE = 24'hF80000;
  localparam logic [23:0] BOOT_SEGMENT_WORD_ADDR = 24'hF80000;
  localparam logic [23:0] GENERAL_SEGMENT_WORD_ADDR = 24'hF80004;
  localparam logic [23:0] OSCILLATOR_CHOICE_WORD_ADDR = 24'hF80006;
  localparam logic [23:0] OSCILLATOR_SETUP_WORD_ADDR = 24'hF80008;
  localparam logic [23:0] WATCHDOG_SETUP_WORD_ADDR = 24'hF8000A;
  localparam logic [23:0] RESET_SETUP_WORD_ADDR = 24'hF8000C;
  localparam logic [23:0] DEBUGGER_SETUP_WORD_ADDR = 24'hF8000E;
  localparam logic [23:0] DEEP_SLEEP_SETUP_WORD_ADDR = 24'hF80010;

  // word indices inside the holding array
  localparam int NUM_WORDS = 8;
  localparam logic [2:0] IDX_BOOT = 3'h0;
  localparam logic [2:0] IDX_GENERAL = 3'h1;
  localparam logic [2:0] IDX_OSC_CHOICE = 3'h2;
  localparam logic [2:0] IDX_OSC_SETUP = 3'h3;
  localparam logic [2:0] IDX_WATCHDOG = 3'h4;
  localparam logic [2:0] IDX_RESET = 3'h5;
  localparam logic [2:0] IDX_DEBUGGER = 3'h6;
  localparam logic [2:0] IDX_DEEP_SLEEP = 3'h7;

  // implemented bit masks; also the erased (unprogrammed) value of each word
  localparam logic [7:0] MASK_BOOT = 8'h0F;
  localparam logic [7:0] MASK_GENERAL = 8'h03;
  localparam logic [7:0] MASK_OSC_CHOICE = 8'h87;
  localparam logic [7:0] MASK_OSC_SETUP = 8'hFF;
  localparam logic [7:0] MASK_WATCHDOG = 8'hDF;
  localparam logic [7:0] MASK_RESET = 8'hFB;
  localparam logic [7:0] MASK_DEBUGGER = 8'h83;
  localparam logic [7:0] MASK_DEEP_SLEEP = 8'hFF;

  // boot segment bounds
  localparam logic [23:0] BOOT_START = 24'h000200;
  localparam logic [23:0] BOOT_END_SMALL = 24'h000AFE;
  localparam logic [23:0] BOOT_END_LARGE = 24'h0015FE;

  // field positions
  localparam int BOOT_WP_BIT = 0;
  localparam int GEN_WP_BIT = 0;
  localparam int GEN_CP_BIT = 1;
  localparam int TWO_SPEED_BIT = 7;
  localparam int SECONDARY_OSCILLATOR_POWER_BIT = 5;
  localparam int CLKOUT_EN_BIT = 2;

  // start-up oscillator codes
  localparam logic [2:0] OSC_FAST_RC = 3'h0;
  localparam logic [2:0] OSC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] OSC_PRIMARY = 3'h2;
  localparam logic [2:0] OSC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] OSC_SECONDARY = 3'h4;
  localparam logic [2:0] OSC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] OSC_LP_FAST_RC_DIV = 3'h6;
  localparam logic [2:0] OSC_FAST_RC_DIV = 3'h7;

  // primary oscillator modes and frequency ranges
  localparam logic [1:0] PMODE_OFF = 2'h3;
  localparam logic [1:0] PMODE_HS = 2'h2;
  localparam logic [1:0] PMODE_XT = 2'h1;
  localparam logic [1:0] PMODE_EC = 2'h0;
  localparam logic [1:0] FREQ_RESERVED = 2'h0;

  // loader sequencing state
  typedef enum logic [1:0] {
    LD_COPY = 2'b01,
    LD_RUN = 2'b10
  } loader_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [23:0] addr;
    logic [7:0] wdata;
  } table_req_t;

  typedef struct packed {
    logic boot_present;
    logic boot_high_security;
    logic boot_code_reserved;
    logic [23:0] boot_end;
    logic boot_write_protect;
    logic general_code_protect;
    logic general_write_protect;
    logic two_speed_startup_enable;
    logic [7:0] startup_osc_onehot;
    logic clock_switch_enable;
    logic fail_safe_enable;
    logic secondary_osc_power_mode;
    logic [1:0] primary_freq_range;
    logic primary_freq_reserved;
    logic clock_output_signal;
    logic primary_osc_on;
    logic crystal_high_speed_mode;
    logic crystal_standard_mode;
    logic external_clock_input_mode;
  } cfg_decoded_t;

endpackage

// >>> hw/cfg_field_decode.sv
`timescale 1ns/1ns
module cfg_field_decode
  import cfg_words_pkg::*;
(
  input wire logic [7:0] boot_segment_word,
  input wire logic [7:0] general_segment_word,
  input wire logic [7:0] oscillator_choice_word,
  input wire logic [7:0] oscillator_setup_word,
  output cfg_decoded_t decoded
);

  wire logic [2:0] boot_code_protect_level = boot_segment_word[3:1];
  wire logic [2:0] startup_oscillator_code = oscillator_choice_word[2:0];
  wire logic [1:0] clock_switch_monitor_code = oscillator_setup_word[7:6];
  wire logic [1:0] primary_osc_mode = oscillator_setup_word[1:0];
  wire logic clock_output_enable = oscillator_setup_word[CLKOUT_EN_BIT];

  // boot segment size and security; low two bits pick size, msb clear means high security
  wire logic boot_small = (boot_code_protect_level == 3'h6) || (boot_code_protect_level == 3'h2);
  wire logic boot_large = (boot_code_protect_level == 3'h5) || (boot_code_protect_level == 3'h1);

  // one-hot view of the start-up source, one bit per code
  wire logic [7:0] osc_onehot;
  for (genvar i = 0; i < 8; i++) begin : g_osc
    assign osc_onehot[i] = (startup_oscillator_code == 3'(i));
  end

  // all field decodes; a programmed (zero) bit selects the protective option
  assign decoded.boot_present = boot_small | boot_large;
  assign decoded.boot_high_security = (boot_small | boot_large) & ~boot_code_protect_level[2];
  assign decoded.boot_code_reserved = ~(boot_small | boot_large) & (boot_code_protect_level != 3'h7);
  assign decoded.boot_end = boot_large ? BOOT_END_LARGE : BOOT_END_SMALL;
  assign decoded.boot_write_protect = ~boot_segment_word[BOOT_WP_BIT];
  assign decoded.general_code_protect = ~general_segment_word[GEN_CP_BIT];
  assign decoded.general_write_protect = ~general_segment_word[GEN_WP_BIT];
  assign decoded.two_speed_startup_enable = oscillator_choice_word[TWO_SPEED_BIT];
  assign decoded.startup_osc_onehot = osc_onehot;
  assign decoded.clock_switch_enable = ~clock_switch_monitor_code[1];
  assign decoded.fail_safe_enable = (clock_switch_monitor_code == 2'h0);
  assign decoded.secondary_osc_power_mode = oscillator_setup_word[SECONDARY_OSCILLATOR_POWER_BIT];
  assign decoded.primary_freq_range = oscillator_setup_word[4:3];
  assign decoded.primary_freq_reserved = (oscillator_setup_word[4:3] == FREQ_RESERVED);
  // clock out only when the primary pins are free: oscillator off or external clock
  assign decoded.clock_output_signal = clock_output_enable &
    ((primary_osc_mode == PMODE_OFF) || (primary_osc_mode == PMODE_EC));
  assign decoded.primary_osc_on = (primary_osc_mode != PMODE_OFF);
  assign decoded.crystal_high_speed_mode = (primary_osc_mode == PMODE_HS);
  assign decoded.crystal_standard_mode = (primary_osc_mode == PMODE_XT);
  assign decoded.external_clock_input_mode = (primary_osc_mode == PMODE_EC);

endmodule

// >>> hw/device_configuration_words.sv
`timescale 1ns/1ns
// Overview of operation
// - programmed bits read zero, unprogrammed read one; value selects the option
// - configuration words start at F80000h, above user program memory
// - 800000h-FFFFFFh reachable only by table reads and writes, never data access
// - eight words at F80000, F80004, F80006, F80008, F8000A, F8000C, F8000E, F80010
// - boot protect level: 111 none, x10 small, x01 large, others reserved
// - boot write protect bit zero blocks all boot segment writes
// - general code protect bit zero enables standard security
// - general write protect bit zero blocks general segment writes
// - general segment protection bits can only be cleared by writes; only an erase or power-on sets them again
// - switchover bit one enables two-speed start-up from internal oscillator
// - three-bit start-up oscillator code selects one of eight clock sources
// - clock switch code: 1x neither, 01 switching only, 00 switching and monitor
// - secondary oscillator power bit one is high power, zero low power
// - primary frequency range: 11 above 8 MHz, 10 middle, 01 low, 00 reserved
// - clock output driven only when enabled and primary mode is 11 or 00
// - primary mode: 11 off, 10 high-speed crystal, 01 crystal, 00 external clock
// - unimplemented bits in every word always read back zero
module device_configuration_words
  import cfg_words_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic por_n,
  input table_req_t table_req,
  output logic [7:0] table_rdata,
  output logic table_ack,
  output logic table_err,
  input wire logic data_req,
  input wire logic [23:0] data_addr,
  output logic data_refused,
  input wire logic flash_wr_req,
  input wire logic [23:0] flash_wr_addr,
  output logic flash_wr_grant,
  output logic flash_wr_deny,
  input wire logic cfg_erase,
  output logic core_release,
  output cfg_decoded_t cfg_decoded,
  output logic [7:0] watchdog_setup_word,
  output logic [7:0] reset_setup_word,
  output logic [7:0] debugger_setup_word,
  output logic [7:0] deep_sleep_setup_word
);

  // per-word implemented masks as a table, indexed like the word arrays
  localparam logic [7:0] WORD_MASK [NUM_WORDS] = '{
    MASK_BOOT, MASK_GENERAL, MASK_OSC_CHOICE, MASK_OSC_SETUP,
    MASK_WATCHDOG, MASK_RESET, MASK_DEBUGGER, MASK_DEEP_SLEEP
  };

  // nonvolatile cells; power-on or an erase returns them to their implemented masks, resetn alone does not
  logic [7:0] cell_q [NUM_WORDS];
  // holding latches that feed the decoders while the core runs
  logic [7:0] hold_q [NUM_WORDS];

  loader_state_t state_q;
  logic [2:0] load_idx_q;
  logic core_release_q;
  logic [7:0] table_rdata_q;
  logic table_ack_q;
  logic table_err_q;
  logic data_refused_q;
  logic flash_wr_grant_q;
  logic flash_wr_deny_q;
  cfg_decoded_t cfg_decoded_q;
  cfg_decoded_t decoded_now;

  // address decode of the table request
  wire logic in_cfg_space = (table_req.addr >= CFG_SPACE_LO) && (table_req.addr <= CFG_SPACE_HI);
  wire logic running = (state_q == LD_RUN);
  wire logic hit_any;
  wire logic [2:0] hit_idx;
  logic hit_boot;
  logic hit_general;
  logic hit_osc_choice;
  logic hit_osc_setup;
  logic hit_watchdog;
  logic hit_reset;
  logic hit_debugger;
  logic hit_deep_sleep;

  // fixed word addresses, all above the user program space
  assign hit_boot = (table_req.addr == BOOT_SEGMENT_WORD_ADDR);
  assign hit_general = (table_req.addr == GENERAL_SEGMENT_WORD_ADDR);
  assign hit_osc_choice = (table_req.addr == OSCILLATOR_CHOICE_WORD_ADDR);
  assign hit_osc_setup = (table_req.addr == OSCILLATOR_SETUP_WORD_ADDR);
  assign hit_watchdog = (table_req.addr == WATCHDOG_SETUP_WORD_ADDR);
  assign hit_reset = (table_req.addr == RESET_SETUP_WORD_ADDR);
  assign hit_debugger = (table_req.addr == DEBUGGER_SETUP_WORD_ADDR);
  assign hit_deep_sleep = (table_req.addr == DEEP_SLEEP_SETUP_WORD_ADDR);

  assign hit_any = hit_boot | hit_general | hit_osc_choice | hit_osc_setup |
                   hit_watchdog | hit_reset | hit_debugger | hit_deep_sleep;

  // index chain; word 0 is the fall-through so a miss must be gated by hit_any
  wire logic [2:0] idx_a = hit_deep_sleep ? IDX_DEEP_SLEEP :
                           hit_debugger ? IDX_DEBUGGER :
                           hit_reset ? IDX_RESET :
                           hit_watchdog ? IDX_WATCHDOG : IDX_BOOT;
  assign hit_idx = hit_osc_setup ? IDX_OSC_SETUP :
                   hit_osc_choice ? IDX_OSC_CHOICE :
                   hit_general ? IDX_GENERAL : idx_a;

  // request qualification; requests during the load are simply not answered
  wire logic tbl_any = table_req.rd | table_req.wr;
  wire logic tbl_take = running & tbl_any;
  wire logic tbl_bad = ~in_cfg_space;
  wire logic tbl_wr_hit = tbl_take & table_req.wr & in_cfg_space & hit_any;

  // read data: unimplemented positions forced low, gaps in the space read zero
  wire logic [7:0] tbl_read_word = hit_any ? (cell_q[hit_idx] & WORD_MASK[hit_idx]) : 8'h00;

  // programming value; general segment bits may only fall, everything else takes the data
  wire logic [7:0] cell_masked_wr = table_req.wdata & WORD_MASK[hit_idx];
  wire logic [7:0] cell_next_wr = (hit_idx == IDX_GENERAL) ?
                                  (cell_q[IDX_GENERAL] & cell_masked_wr) : cell_masked_wr;

  // ordinary data accesses into configuration space are refused
  wire logic data_hits_cfg = data_req && (data_addr >= CFG_SPACE_LO);

  // nonvolatile cell array, one entry per word
  for (genvar w = 0; w < NUM_WORDS; w++) begin : g_cell
    always_ff @(posedge core_clk or negedge por_n) begin
      if (!por_n) begin
        cell_q[w] <= WORD_MASK[w];
      end else if (cfg_erase) begin
        cell_q[w] <= WORD_MASK[w];
      end else if (tbl_wr_hit && (hit_idx == 3'(w))) begin
        cell_q[w] <= cell_next_wr;
      end
    end
  end

  // holding latches; filled one word per cycle after reset release, then frozen
  for (genvar h = 0; h < NUM_WORDS; h++) begin : g_hold
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        hold_q[h] <= 8'hFF;
      end else if ((state_q == LD_COPY) && (load_idx_q == 3'(h))) begin
        hold_q[h] <= cell_q[h] & WORD_MASK[h];
      end
    end
  end

  // loader sequence: copy every word, then release the core
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= LD_COPY;
      load_idx_q <= 3'h0;
      core_release_q <= 1'b0;
    end else begin
      case (state_q)
        LD_COPY: begin
          load_idx_q <= load_idx_q + 3'h1;
          if (load_idx_q == 3'(NUM_WORDS - 1)) begin
            state_q <= LD_RUN;
            core_release_q <= 1'b1;
          end
        end
        LD_RUN: begin
          state_q <= LD_RUN;
        end
        default: begin
          state_q <= LD_COPY;
          load_idx_q <= 3'h0;
          core_release_q <= 1'b0;
        end
      endcase
    end
  end

  // table port answer, one cycle after the request is taken
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      table_rdata_q <= 8'h00;
      table_ack_q <= 1'b0;
      table_err_q <= 1'b0;
    end else begin
      table_ack_q <= tbl_take;
      table_err_q <= tbl_take & tbl_bad;
      if (tbl_take && table_req.rd && !tbl_bad) begin
        table_rdata_q <= tbl_read_word;
      end else if (tbl_take) begin
        table_rdata_q <= 8'h00;
      end
    end
  end

  // data access refusal flag, one cycle pulse
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_refused_q <= 1'b0;
    end else begin
      data_refused_q <= running & data_hits_cfg;
    end
  end

  // decoders see only the frozen holding latches, so settings never move while running
  cfg_field_decode u_decode (
    .boot_segment_word(hold_q[IDX_BOOT]),
    .general_segment_word(hold_q[IDX_GENERAL]),
    .oscillator_choice_word(hold_q[IDX_OSC_CHOICE]),
    .oscillator_setup_word(hold_q[IDX_OSC_SETUP]),
    .decoded(decoded_now)
  );

  // flash write permission against the boot and general segments
  wire logic fw_in_boot = decoded_now.boot_present &&
                          (flash_wr_addr >= BOOT_START) && (flash_wr_addr <= decoded_now.boot_end);
  wire logic fw_in_user = (flash_wr_addr < CFG_SPACE_LO);
  wire logic fw_blocked_boot = fw_in_boot & decoded_now.boot_write_protect;
  wire logic fw_blocked_gen = fw_in_user & ~fw_in_boot & decoded_now.general_write_protect;
  wire logic fw_blocked = fw_blocked_boot | fw_blocked_gen | ~fw_in_user;
  wire logic fw_take = running & flash_wr_req;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flash_wr_grant_q <= 1'b0;
      flash_wr_deny_q <= 1'b0;
    end else begin
      flash_wr_grant_q <= fw_take & ~fw_blocked;
      flash_wr_deny_q <= fw_take & fw_blocked;
    end
  end

  // decoded settings registered; cleared by reset, then follow the holding latch decode every cycle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_decoded_q <= '0;
    end else begin
      cfg_decoded_q <= decoded_now;
    end
  end

  // raw later words for the watchdog, reset, debug and deep sleep logic elsewhere
  assign watchdog_setup_word = hold_q[IDX_WATCHDOG];
  assign reset_setup_word = hold_q[IDX_RESET];
  assign debugger_setup_word = hold_q[IDX_DEBUGGER];
  assign deep_sleep_setup_word = hold_q[IDX_DEEP_SLEEP];

  // outputs straight from flip-flops
  assign table_rdata = table_rdata_q;
  assign table_ack = table_ack_q;
  assign table_err = table_err_q;
  assign data_refused = data_refused_q;
  assign flash_wr_grant = flash_wr_grant_q;
  assign flash_wr_deny = flash_wr_deny_q;
  assign core_release = core_release_q;
  assign cfg_decoded = cfg_decoded_q;

endmodule

// >>> dv/cfg_words_sva.sv
`timescale 1ns/1ns
module cfg_words_sva
  import cfg_words_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input table_req_t table_req,
  input wire logic [7:0] table_rdata,
  input wire logic table_ack,
  input wire logic table_err,
  input wire logic data_req,
  input wire logic [23:0] data_addr,
  input wire logic data_refused,
  input wire logic flash_wr_req,
  input wire logic [23:0] flash_wr_addr,
  input wire logic flash_wr_deny,
  input wire logic core_release,
  input cfg_decoded_t cfg_decoded,
  input wire logic [7:0] watchdog_setup_word,
  input wire logic [7:0] reset_setup_word,
  input wire logic [7:0] debugger_setup_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // request qualifiers shared by the table port checks
  wire req_taken = core_release && (table_req.rd || table_req.wr);
  wire req_outside = table_req.addr < CFG_SPACE_LO;

  // loader holds the core for eight edges after reset release
  sequence load_wait;
    !core_release [*8] ##1 core_release;
  endsequence

  load_seq_a: assert property ($rose(resetn) |-> load_wait)
    else $error("core released at the wrong edge after reset");
  decode_stable_a: assert property (core_release && $past(core_release, 2) |-> $stable(cfg_decoded))
    else $error("decoded settings moved while running");
  table_ack_a: assert property (req_taken |=> table_ack)
    else $error("table request not acknowledged");
  table_err_a: assert property (req_taken && req_outside |=> table_err && table_rdata == 8'h00)
    else $error("table access outside config space not flagged");
  data_block_a: assert property (core_release && data_req && data_addr >= CFG_SPACE_LO |=> data_refused)
    else $error("data access reached config space");
  flash_deny_a: assert property (core_release && flash_wr_req && flash_wr_addr >= CFG_SPACE_LO |=> flash_wr_deny)
    else $error("flash write into config space not denied");
  boot_rd_zero_a: assert property (table_ack && $past(table_req.addr) == BOOT_SEGMENT_WORD_ADDR
    |-> table_rdata[7:4] == 4'h0)
    else $error("boot word upper bits not zero");
  unimpl_zero_a: assert property (core_release |-> watchdog_setup_word[5] == 1'b0 && reset_setup_word[2] == 1'b0
    && debugger_setup_word[6:2] == 5'h00)
    else $error("unimplemented holding bits not zero");
  clk_out_a: assert property (cfg_decoded.clock_output_signal
    |-> !cfg_decoded.crystal_high_speed_mode && !cfg_decoded.crystal_standard_mode)
    else $error("clock output with a crystal mode");
  boot_end_a: assert property (cfg_decoded.boot_present
    |-> cfg_decoded.boot_end == BOOT_END_SMALL || cfg_decoded.boot_end == BOOT_END_LARGE)
    else $error("boot segment end not a legal bound");
endmodule

bind device_configuration_words cfg_words_sva i_cfg_words_sva (.core_clk(core_clk), .resetn(resetn),
  .table_req(table_req), .table_rdata(table_rdata), .table_ack(table_ack), .table_err(table_err),
  .data_req(data_req), .data_addr(data_addr), .data_refused(data_refused), .flash_wr_req(flash_wr_req),
  .flash_wr_addr(flash_wr_addr), .flash_wr_deny(flash_wr_deny), .core_release(core_release),
  .cfg_decoded(cfg_decoded), .watchdog_setup_word(watchdog_setup_word), .reset_setup_word(reset_setup_word),
  .debugger_setup_word(debugger_setup_word));

// >>> dv/tb.sv
`timescale 1ns/1ns
module tb
  import cfg_words_pkg::*;
;
  logic core_clk = 0, resetn = 0, por_n = 0, data_req = 0, flash_wr_req = 0, cfg_erase = 0;
  logic [23:0] data_addr = '0, flash_wr_addr = '0;
  table_req_t table_req = '0;
  logic [7:0] table_rdata, wd_word, rs_word, db_word, ds_word;
  logic table_ack, table_err, data_refused, flash_wr_grant, flash_wr_deny, core_release;
  cfg_decoded_t cfg_decoded;
  int num_errors = 0, samples_checked = 0;

  device_configuration_words i_device_configuration_words (.core_clk(core_clk), .resetn(resetn), .por_n(por_n),
    .table_req(table_req), .table_rdata(table_rdata), .table_ack(table_ack), .table_err(table_err),
    .data_req(data_req), .data_addr(data_addr), .data_refused(data_refused), .flash_wr_req(flash_wr_req),
    .flash_wr_addr(flash_wr_addr), .flash_wr_grant(flash_wr_grant), .flash_wr_deny(flash_wr_deny),
    .cfg_erase(cfg_erase), .core_release(core_release), .cfg_decoded(cfg_decoded),
    .watchdog_setup_word(wd_word), .reset_setup_word(rs_word), .debugger_setup_word(db_word),
    .deep_sleep_setup_word(ds_word));

  // 20 MHz core clock
  always #25 core_clk = ~core_clk;

  task cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // reset pulse; por also erases the cells, plain reset only reloads them
  task do_reset(input logic por);
    int n;
    @(posedge core_clk);
    resetn <= 0;
    if (por) por_n <= 0;
    repeat (3) @(posedge core_clk);
    por_n <= 1;
    resetn <= 1;
    n = 0;
    #1;
    while (core_release !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    cmp(core_release, 1, "core release");
    @(posedge core_clk);
    #1;
  endtask

  // one table cycle; request held for exactly the taking edge
  task tbl(input logic rd, input logic wr, input logic [23:0] addr, input logic [7:0] wd, output logic [7:0] rdat,
           output logic err);
    int n;
    @(posedge core_clk);
    table_req <= '{rd, wr, addr, wd};
    @(posedge core_clk);
    table_req <= '0;
    n = 0;
    #1;
    while (table_ack !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    cmp(table_ack, 1, "table ack");
    rdat = table_rdata;
    err = table_err;
  endtask

  task rd_chk(input logic [23:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic e;
    tbl(1, 0, addr, 8'h00, d, e);
    cmp({e, d}, {1'b0, exp}, "table read");
  endtask

  task wr(input logic [23:0] addr, input logic [7:0] wd);
    logic [7:0] d;
    logic e;
    tbl(0, 1, addr, wd, d, e);
  endtask

  // result is {grant, deny} for flash, {0, refused} for data
  task probe(input logic flash, input logic [23:0] addr, input logic [1:0] exp);
    @(posedge core_clk);
    if (flash) begin
      flash_wr_req <= 1;
      flash_wr_addr <= addr;
    end else begin
      data_req <= 1;
      data_addr <= addr;
    end
    @(posedge core_clk);
    flash_wr_req <= 0;
    data_req <= 0;
    #1;
    cmp(flash ? {flash_wr_grant, flash_wr_deny} : {1'b0, data_refused}, exp, "probe");
  endtask

  task erase;
    @(posedge core_clk);
    cfg_erase <= 1;
    @(posedge core_clk);
    cfg_erase <= 0;
  endtask

  task test_erased;
    logic [7:0] m [8];
    m = '{MASK_BOOT, MASK_GENERAL, MASK_OSC_CHOICE, MASK_OSC_SETUP, MASK_WATCHDOG, MASK_RESET, MASK_DEBUGGER,
          MASK_DEEP_SLEEP};
    for (int i = 0; i < 8; i++) begin
      rd_chk(CFG_BASE + ((i == 0) ? 24'h0 : 24'(2 * i + 2)), m[i]);
    end
    cmp({wd_word, rs_word, db_word}, {MASK_WATCHDOG, MASK_RESET, MASK_DEBUGGER}, "holding words");
    cmp(ds_word, MASK_DEEP_SLEEP, "deep sleep word");
    cmp({cfg_decoded.startup_osc_onehot, cfg_decoded.boot_present}, {8'h80, 1'b0}, "erased decode");
    $display("test erased done");
  endtask

  task test_access;
    logic [7:0] d;
    logic e;
    rd_chk(24'hF80002, 8'h00);
    tbl(1, 0, 24'h001000, 8'h00, d, e);
    cmp(e, 1, "outside error");
    probe(0, BOOT_SEGMENT_WORD_ADDR, 2'b01);
    probe(0, 24'h001000, 2'b00);
    probe(1, GENERAL_SEGMENT_WORD_ADDR, 2'b01);
    wr(GENERAL_SEGMENT_WORD_ADDR, 8'h01);
    wr(GENERAL_SEGMENT_WORD_ADDR, 8'h03);
    rd_chk(GENERAL_SEGMENT_WORD_ADDR, 8'h01);
    erase();
    rd_chk(GENERAL_SEGMENT_WORD_ADDR, 8'h03);
    $display("test access done");
  endtask

  // every boot, oscillator, switch, mode and range code, reloaded through reset
  task test_decode;
    logic [2:0] c;
    logic pres;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(BOOT_SEGMENT_WORD_ADDR, {4'hF, c, 1'b1});
      wr(OSCILLATOR_CHOICE_WORD_ADDR, {c[0], 4'hF, c});
      wr(OSCILLATOR_SETUP_WORD_ADDR, {c[1:0], c[2], c[1:0], c[2], c[1:0]});
      do_reset(0);
      rd_chk(BOOT_SEGMENT_WORD_ADDR, {4'h0, c, 1'b1});
      rd_chk(OSCILLATOR_CHOICE_WORD_ADDR, {c[0], 4'h0, c});
      pres = (c == 3'h6 || c == 3'h2 || c == 3'h5 || c == 3'h1);
      cmp(cfg_decoded.boot_present, pres, "boot present");
      cmp({cfg_decoded.boot_high_security, cfg_decoded.boot_code_reserved}, {pres && !c[2], !pres && c != 3'h7},
          "boot kind");
      // large boot codes are fine here: this is the full-memory member
      if (pres) cmp(cfg_decoded.boot_end, c[1] ? BOOT_END_SMALL : BOOT_END_LARGE, "boot end");
      cmp(cfg_decoded.startup_osc_onehot, 8'h01 << c, "osc code");
      cmp(cfg_decoded.two_speed_startup_enable, c[0], "two speed");
      cmp({cfg_decoded.clock_switch_enable, cfg_decoded.fail_safe_enable}, {!c[1], c[1:0] == 2'h0},
          "switch");
      cmp({cfg_decoded.primary_freq_range, cfg_decoded.primary_freq_reserved, cfg_decoded.secondary_osc_power_mode},
          {c[1:0], c[1:0] == 2'h0, c[2]}, "range");
      cmp({cfg_decoded.crystal_high_speed_mode, cfg_decoded.crystal_standard_mode,
           cfg_decoded.external_clock_input_mode, cfg_decoded.primary_osc_on},
          {c[1:0] == 2'h2, c[1:0] == 2'h1, c[1:0] == 2'h0, c[1:0] != 2'h3}, "mode");
      cmp(cfg_decoded.clock_output_signal, c[2] && (c[1:0] == 2'h3 || c[1:0] == 2'h0), "clock out");
    end
    $display("test decode done");
  endtask

  // segment write protection seen through the flash permission port
  task test_protect;
    wr(BOOT_SEGMENT_WORD_ADDR, 8'h0C);
    wr(GENERAL_SEGMENT_WORD_ADDR, 8'h00);
    do_reset(0);
    cmp({cfg_decoded.boot_write_protect, cfg_decoded.general_code_protect, cfg_decoded.general_write_protect}, 3'h7,
        "protect on");
    probe(1, 24'h000300, 2'b01);
    probe(1, 24'h001000, 2'b01);
    erase();
    wr(BOOT_SEGMENT_WORD_ADDR, 8'h0D);
    do_reset(0);
    cmp({cfg_decoded.boot_write_protect, cfg_decoded.general_code_protect, cfg_decoded.general_write_protect}, 3'h0,
        "protect off");
    probe(1, 24'h000300, 2'b10);
    probe(1, 24'h001000, 2'b10);
    $display("test protect done");
  endtask

  task end_sim;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(1);
    test_erased();
    test_access();
    test_decode();
    test_protect();
    end_sim();
  end

  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    #500000;
    num_errors++;
    end_sim();
  end
endmodule
